/* rtl/dhp_port.sv */
// Top of the display host port: serial command port and RGB pixel port
//----------------------------------------------------------------------
// Overview of operation
// [RULE1] Serial read output changes after each falling serial clock edge.
// [RULE2] Serial write input is captured on each rising serial clock edge.
// [RULE3] First word bit 1 marks parameter data, 0 marks a command.
// [RULE4] Serial clock pin clocks 9-bit words supplied by the host.
// [RULE5] Serial lines matter only while chip select is low.
// [RULE6] Low reset pin initializes the controller; host resets after power-up.
// [RULE7] Pixels arrive on a parallel bus of up to 24 bits.
// [RULE8] Pixel bus width is 16, 18 or 24 bits as configured.
// [RULE9] Pixel words are taken only while data enable is high.
// [RULE10] Host supplies a continuous pixel clock timing all pixel signals.
// [RULE11] Host pulses line sync once per line.
// [RULE12] Host pulses frame sync once per frame.
// [RULE13] Each frame carries 480 pixels by 854 active lines.
// [RULE14] Word order: command flag first, then eight payload bits MSB first.
// [RULE15] Host holds data enable low during all blanking.
//----------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none

module dhp_port (
   input  wire logic                          mclk,
   input  wire logic                          sys_rst,
   input  wire logic                          panel_reset_n,
   input  wire logic                          serial_clock,
   input  wire logic                          serial_cs_n,
   input  wire logic                          serial_write_in,
   output logic                               serial_read_out,
   output logic                               serial_read_oe,
   input  wire logic [dhp_pkg::PAY_W-1:0]     reply_byte,
   output dhp_pkg::dhp_word_t                 word_out,
   output logic                               word_valid,
   output logic                               ctrl_ready,
   input  wire dhp_pkg::dhp_width_t           pixel_width,
   input  wire logic                          pixel_clock,
   input  wire logic [dhp_pkg::PIX_BITS-1:0]  pixel_bus,
   input  wire logic                          pixel_valid,
   input  wire logic                          line_sync_n,
   input  wire logic                          frame_sync_n,
   output dhp_pkg::dhp_pix_t                  pix_out,
   output logic                               pix_out_valid,
   output logic [dhp_pkg::CNT_W-1:0]          frame_count,
   output logic                               line_error,
   output logic                               frame_error,
   input  wire logic                          status_clear
);
   import dhp_pkg::*;

   //------------------------------------------------------------------
   // Declarations
   //------------------------------------------------------------------
   logic [3:0]          pin_s;
   logic                prst_n_s;
   logic                cs_n_s;
   logic                sclk_s;
   logic                sdi_s;
   logic                core_rst;
   logic                sclk_prev_q;
   logic                rise;
   logic                fall;
   logic [BITCNT_W-1:0] bit_cnt_q;
   logic [PAY_W-1:0]    shift_q;
   logic [PAY_W-1:0]    reply_q;
   logic                dc_q;
   logic                ready_q;
   dhp_width_t          width_q;
   logic [1:0]          width_px;
   logic                pix_rst;
   logic [EVT_W-1:0]    evt_tgl;
   logic [EVT_W-1:0]    evt_s;
   logic [EVT_W-1:0]    evt_prev_q;
   logic [EVT_W-1:0]    evt_pulse;

   //------------------------------------------------------------------
   // Pin synchronizers
   //------------------------------------------------------------------
   // Pins are oversampled, so the serial clock must stay well below
   // a quarter of mclk for every edge to be seen.
   dhp_sync2 #(
      .W    (4),
      .INIT (4'h4)
   ) u_pin_sync (
      .clk (mclk),
      .rst (sys_rst),
      .d   ({panel_reset_n, serial_cs_n, serial_clock, serial_write_in}),
      .q   (pin_s)
   );

   assign prst_n_s = pin_s[3];
   assign cs_n_s   = pin_s[2];
   assign sclk_s   = pin_s[1];
   assign sdi_s    = pin_s[0];

   // Pin reset holds every part of the block but the pin synchronizer in its initial state
   assign core_rst = sys_rst | ~prst_n_s;  // [RULE6]

   always_ff @(posedge mclk) begin
      if (core_rst) begin
         ready_q <= 1'h0;  // [RULE6]
      end else begin
         ready_q <= 1'h1;
      end
   end

   assign ctrl_ready = ready_q;

   //------------------------------------------------------------------
   // Serial clock edges
   //------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (core_rst) begin
         sclk_prev_q <= 1'h0;
      end else begin
         sclk_prev_q <= sclk_s;
      end
   end

   assign rise = sclk_s & ~sclk_prev_q & ~cs_n_s;  // [RULE5]
   assign fall = ~sclk_s & sclk_prev_q & ~cs_n_s;  // [RULE5]

   //------------------------------------------------------------------
   // Serial receive
   //------------------------------------------------------------------
   // Raising chip select abandons any partial word
   always_ff @(posedge mclk) begin
      if (core_rst || cs_n_s) begin
         bit_cnt_q <= '0;  // [RULE5]
      end else if (rise) begin
         if (bit_cnt_q == WORD_LAST) begin
            bit_cnt_q <= '0;  // [RULE4]
         end else begin
            bit_cnt_q <= bit_cnt_q + 1'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (core_rst) begin
         shift_q <= '0;
      end else if (rise) begin
         shift_q <= {shift_q[PAY_W-2:0], sdi_s};  // [RULE2]
      end
   end

   // Copy of the first bit of the word, kept for checking
   always_ff @(posedge mclk) begin
      if (core_rst) begin
         dc_q <= DC_COMMAND;
      end else if (rise && bit_cnt_q == '0) begin
         dc_q <= sdi_s;
      end
   end

   // The oldest bit in the shifter is the command flag
   always_ff @(posedge mclk) begin
      if (core_rst) begin
         word_valid <= 1'h0;
         word_out   <= '0;
      end else begin
         word_valid <= rise && bit_cnt_q == WORD_LAST;  // [RULE4]
         if (rise && bit_cnt_q == WORD_LAST) begin
            word_out <= '{data_command_select: shift_q[PAY_W-1],  // [RULE3] [RULE14]
                          payload: {shift_q[PAY_W-2:0], sdi_s}};  // [RULE14]
         end
      end
   end

   //------------------------------------------------------------------
   // Serial transmit
   //------------------------------------------------------------------
   // Flag slot sends zero; reply byte follows MSB first
   always_ff @(posedge mclk) begin
      if (core_rst) begin
         serial_read_out <= 1'h0;
         reply_q         <= '0;
      end else if (fall) begin
         if (bit_cnt_q == '0) begin
            serial_read_out <= 1'h0;  // [RULE1]
            reply_q         <= reply_byte;
         end else begin
            serial_read_out <= reply_q[PAY_W-1];  // [RULE1] [RULE14]
            reply_q         <= {reply_q[PAY_W-2:0], 1'h0};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (core_rst) begin
         serial_read_oe <= 1'h0;
      end else begin
         serial_read_oe <= ~cs_n_s;  // [RULE5]
      end
   end

   //------------------------------------------------------------------
   // Pixel domain
   //------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (core_rst) begin
         width_q <= DHP_BUS24;
      end else begin
         width_q <= pixel_width;
      end
   end

   // Pixel clock is continuous, so its reset follows within two edges
   dhp_sync2 #(
      .W    (1),
      .INIT (1'h1)
   ) u_pix_rst_sync (
      .clk (pixel_clock),  // [RULE10]
      .rst (1'h0),
      .d   (core_rst),
      .q   (pix_rst)
   );

   // Width is quasi-static; change it only between frames
   dhp_sync2 #(
      .W    (2),
      .INIT (2'h2)
   ) u_width_sync (
      .clk (pixel_clock),
      .rst (pix_rst),
      .d   (width_q),
      .q   (width_px)
   );

   dhp_pixel_rx u_pixel_rx (
      .pixel_clock   (pixel_clock),
      .pix_rst       (pix_rst),
      .width         (dhp_width_t'(width_px)),
      .pixel_bus     (pixel_bus),  // [RULE7]
      .pixel_valid   (pixel_valid),
      .line_sync_n   (line_sync_n),
      .frame_sync_n  (frame_sync_n),
      .pix_out       (pix_out),
      .pix_out_valid (pix_out_valid),
      .evt_tgl       (evt_tgl)
   );

   //------------------------------------------------------------------
   // Frame status
   //------------------------------------------------------------------
   dhp_sync2 #(
      .W    (EVT_W),
      .INIT ('0)
   ) u_evt_sync (
      .clk (mclk),
      .rst (core_rst),
      .d   (evt_tgl),
      .q   (evt_s)
   );

   always_ff @(posedge mclk) begin
      if (core_rst) begin
         evt_prev_q <= '0;
      end else begin
         evt_prev_q <= evt_s;
      end
   end

   assign evt_pulse = evt_s ^ evt_prev_q;

   always_ff @(posedge mclk) begin
      if (core_rst) begin
         frame_count <= '0;
      end else if (evt_pulse[EVT_FRAME]) begin
         frame_count <= frame_count + 1'h1;
      end
   end

   // A new error in the clearing cycle keeps its flag set
   always_ff @(posedge mclk) begin
      if (core_rst) begin
         line_error  <= 1'h0;
         frame_error <= 1'h0;
      end else begin
         line_error  <= evt_pulse[EVT_LINE_ERR] | (line_error & ~status_clear);  // [RULE13]
         frame_error <= evt_pulse[EVT_FRAME_ERR] | (frame_error & ~status_clear);  // [RULE13]
      end
   end

   //------------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (core_rst);

   sdo_on_fall_a: assert property ( // [RULE1]
      $changed(serial_read_out) |-> $past(fall))
      else $error("serial output changed off a falling edge");

   sdi_on_rise_a: assert property ( // [RULE2]
      word_valid |-> $past(rise) && word_out.payload[0] == $past(sdi_s))
      else $error("word not completed by a rising edge capture");

   dc_first_a: assert property ( // [RULE3]
      word_valid |-> word_out.data_command_select == $past(dc_q))
      else $error("command flag is not the first bit of the word");

   nine_bits_a: assert property ( // [RULE4]
      (rise && bit_cnt_q == WORD_LAST) |=> word_valid ##1 !word_valid)
      else $error("word not produced after nine bits");

   cs_ignore_a: assert property ( // [RULE5]
      cs_n_s |=> bit_cnt_q == '0 && !word_valid && !serial_read_oe)
      else $error("serial port active while deselected");

   payload_msb_a: assert property ( // [RULE14]
      (fall && bit_cnt_q != '0) |=> serial_read_out == $past(reply_q[PAY_W-1]))
      else $error("reply not sent most significant bit first");

   err_set_wins_a: assert property ( // [RULE13]
      evt_pulse[EVT_LINE_ERR] |=> line_error)
      else $error("line error lost against clear");

   reset_init_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE6]
      !prst_n_s |=> !ctrl_ready && !word_valid && bit_cnt_q == '0)
      else $error("pin reset did not initialize the port");

   ready_rel_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE6]
      $rose(prst_n_s) |=> ctrl_ready [*2])
      else $error("ready not raised after reset release");

   cmd_word_c: cover property (word_valid && word_out.data_command_select == DC_COMMAND);
   data_word_c: cover property (word_valid && word_out.data_command_select == DC_DATA);
   frame_seen_c: cover property (evt_pulse[EVT_FRAME] ##1 !line_error && !frame_error);
   line_err_c: cover property ($rose(line_error));

endmodule : dhp_port

`default_nettype wire

/* rtl/dhp_pkg.sv */
// Shared constants, types and pixel expansion of the display host port
package dhp_pkg;

   //------------------------------------------------------------------
   // Frame geometry and word sizes
   //------------------------------------------------------------------
   localparam int unsigned WORD_BITS = 9;
   localparam int unsigned BITCNT_W  = 4;
   localparam int unsigned PIX_BITS  = 24;
   localparam int unsigned COL_W     = 9;
   localparam int unsigned ROW_W     = 10;
   localparam int unsigned CNT_W     = 16;
   localparam int unsigned PAY_W     = 8;

   localparam logic [BITCNT_W-1:0] WORD_LAST  = 4'h8;    // Ninth bit of a word
   localparam logic [COL_W-1:0]    ACT_PIXELS = 9'h1e0;  // 480 pixels a line
   localparam logic [ROW_W-1:0]    ACT_LINES  = 10'h356; // 854 lines a frame
   localparam logic                DC_DATA    = 1'h1;
   localparam logic                DC_COMMAND = 1'h0;

   // Event toggles sent from the pixel clock domain
   localparam int unsigned EVT_W         = 3;
   localparam int unsigned EVT_FRAME     = 0;
   localparam int unsigned EVT_LINE_ERR  = 1;
   localparam int unsigned EVT_FRAME_ERR = 2;

   //------------------------------------------------------------------
   // Types
   //------------------------------------------------------------------
   typedef enum logic [1:0] {
      DHP_BUS16 = 2'h0,
      DHP_BUS18 = 2'h1,
      DHP_BUS24 = 2'h2
   } dhp_width_t;

   typedef struct packed {
      logic             data_command_select;
      logic [PAY_W-1:0] payload;
   } dhp_word_t;

   typedef struct packed {
      logic [PIX_BITS-1:0] rgb;
      logic [COL_W-1:0]    col;
      logic [ROW_W-1:0]    row;
   } dhp_pix_t;

   // Narrow formats are widened by repeating their top bits
   function automatic logic [PIX_BITS-1:0] dhp_expand(input dhp_width_t w,
                                                      input logic [PIX_BITS-1:0] b);
      case (w)
         DHP_BUS16: dhp_expand = {b[15:11], b[15:13], b[10:5], b[10:9], b[4:0], b[4:2]};
         DHP_BUS18: dhp_expand = {b[17:12], b[17:16], b[11:6], b[11:10], b[5:0], b[5:4]};
         default:   dhp_expand = b;
      endcase
   endfunction : dhp_expand

endpackage : dhp_pkg

/* rtl/dhp_sync2.sv */
// Two-stage synchronizer for levels entering a clock domain
`timescale 1ns/10ps
`default_nettype none

module dhp_sync2 #(
   parameter int unsigned  W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;

   // First stage feeds the second stage only
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= INIT;
         q      <= INIT;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : dhp_sync2

`default_nettype wire

/* rtl/dhp_pixel_rx.sv */
// RGB pixel receiver running on the host's pixel clock
`timescale 1ns/10ps
`default_nettype none

module dhp_pixel_rx (
   input  wire logic                          pixel_clock,
   input  wire logic                          pix_rst,
   input  wire dhp_pkg::dhp_width_t           width,
   input  wire logic [dhp_pkg::PIX_BITS-1:0]  pixel_bus,
   input  wire logic                          pixel_valid,
   input  wire logic                          line_sync_n,
   input  wire logic                          frame_sync_n,
   output dhp_pkg::dhp_pix_t                  pix_out,
   output logic                               pix_out_valid,
   output logic [dhp_pkg::EVT_W-1:0]          evt_tgl
);
   import dhp_pkg::*;

   typedef enum logic [0:0] {
      PX_WAIT = 1'h0,
      PX_RUN  = 1'h1
   } dhp_px_st_t;

   dhp_px_st_t       st_q;
   logic             ls_q;
   logic             fs_q;
   logic             de_q;
   logic [COL_W-1:0] col_q;
   logic [ROW_W-1:0] row_q;
   logic             line_start;
   logic             frame_start;
   logic             run_end;
   logic             take;

   // Syncs and enable are on this clock already, so no synchronizer
   assign line_start  = ls_q & ~line_sync_n;   // [RULE11]
   assign frame_start = fs_q & ~frame_sync_n;  // [RULE12]
   assign run_end     = de_q & ~pixel_valid & (st_q == PX_RUN);  // [RULE15]
   assign take        = pixel_valid & (st_q == PX_RUN);          // [RULE9]

   always_ff @(posedge pixel_clock) begin
      if (pix_rst) begin
         ls_q <= 1'h1;
         fs_q <= 1'h1;
         de_q <= 1'h0;
      end else begin
         ls_q <= line_sync_n;
         fs_q <= frame_sync_n;
         de_q <= pixel_valid;
      end
   end

   // Pixels before the first frame start have no row and are dropped
   always_ff @(posedge pixel_clock) begin
      if (pix_rst) begin
         st_q <= PX_WAIT;
      end else if (frame_start) begin
         st_q <= PX_RUN;
      end
   end

   always_ff @(posedge pixel_clock) begin
      if (pix_rst || frame_start || line_start) begin
         col_q <= '0;
      end else if (take && col_q != '1) begin
         col_q <= col_q + 1'h1;
      end
   end

   always_ff @(posedge pixel_clock) begin
      if (pix_rst || frame_start) begin
         row_q <= '0;
      end else if (run_end && row_q != '1) begin
         row_q <= row_q + 1'h1;
      end
   end

   always_ff @(posedge pixel_clock) begin
      if (pix_rst) begin
         pix_out_valid <= 1'h0;
         pix_out       <= '0;
      end else begin
         pix_out_valid <= take;  // [RULE9]
         if (take) begin
            pix_out <= '{rgb: dhp_expand(width, pixel_bus), col: col_q, row: row_q};  // [RULE8]
         end
      end
   end

   // Events leave as toggles; the system side detects each change
   always_ff @(posedge pixel_clock) begin
      if (pix_rst) begin
         evt_tgl <= '0;
      end else begin
         if (frame_start) begin
            evt_tgl[EVT_FRAME] <= ~evt_tgl[EVT_FRAME];
         end
         if (run_end && col_q != ACT_PIXELS) begin
            evt_tgl[EVT_LINE_ERR] <= ~evt_tgl[EVT_LINE_ERR];  // [RULE13]
         end
         if (frame_start && st_q == PX_RUN && row_q != ACT_LINES) begin
            evt_tgl[EVT_FRAME_ERR] <= ~evt_tgl[EVT_FRAME_ERR];  // [RULE13]
         end
      end
   end

   //------------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------------
   accept_de_a: assert property (@(posedge pixel_clock) disable iff (pix_rst) // [RULE9]
      pix_out_valid |-> $past(pixel_valid) && $past(st_q) == PX_RUN)
      else $error("pixel taken without data enable");

   pix_width_a: assert property (@(posedge pixel_clock) disable iff (pix_rst) // [RULE8]
      pix_out_valid |-> pix_out.rgb == dhp_expand($past(width), $past(pixel_bus)))
      else $error("pixel not widened per configured bus width");

   line_len_a: assert property (@(posedge pixel_clock) disable iff (pix_rst) // [RULE13]
      (run_end && col_q != ACT_PIXELS) |=> $changed(evt_tgl[EVT_LINE_ERR]))
      else $error("short or long line not flagged");

endmodule : dhp_pixel_rx

`default_nettype wire

/* tb/dhp_host_model.sv */
// Behavioural host display controller driving the serial and RGB lines
`timescale 1ns/10ps
`default_nettype none

module dhp_host_model (
   output logic        serial_clock,
   output logic        serial_cs_n,
   output logic        serial_write_in,
   input  wire logic   serial_read_out,
   output logic        pixel_clock,
   output logic [23:0] pixel_bus,
   output logic        pixel_valid,
   output logic        line_sync_n,
   output logic        frame_sync_n
);
   initial begin
      serial_clock    = 1'h0;
      serial_cs_n     = 1'h1;
      serial_write_in = 1'h0;
      pixel_clock     = 1'h0;
      pixel_bus       = 24'h000000;
      pixel_valid     = 1'h0;
      line_sync_n     = 1'h1;
      frame_sync_n    = 1'h1;
   end

   // Free running, the panel needs it between frames too
   always #16 pixel_clock = ~pixel_clock;

   //------------------------------------------------------------------
   // Serial words; sel low leaves chip select high to show it is ignored
   //------------------------------------------------------------------
   task xfer(input logic [8:0] w, input int n, input logic sel, output logic [7:0] rd);
      int i;
      rd = 8'h00;
      serial_cs_n = ~sel;
      #200;
      for (i = 0; i < n; i++) begin
         serial_write_in = w[8-i];
         #200 serial_clock = 1'h1;
         if (i > 0) rd = {rd[6:0], serial_read_out};
         #200 serial_clock = 1'h0;
      end
      // Released data line must not keep its last level
      serial_write_in = ~serial_write_in;
      #200 serial_cs_n = 1'h1;
      #400;
   endtask : xfer

   //------------------------------------------------------------------
   // RGB traffic, all launched off the rising pixel clock
   //------------------------------------------------------------------
   task frame_start();
      @(posedge pixel_clock) frame_sync_n <= 1'h0;
      @(posedge pixel_clock) frame_sync_n <= 1'h1;
   endtask : frame_start

   task line(input int n, input logic [23:0] v);
      int i;
      @(posedge pixel_clock) line_sync_n <= 1'h0;
      @(posedge pixel_clock) line_sync_n <= 1'h1;
      repeat (2) @(posedge pixel_clock);
      for (i = 0; i < n; i++) begin
         @(posedge pixel_clock) pixel_valid <= 1'h1;
         pixel_bus <= v;
      end
      @(posedge pixel_clock) pixel_valid <= 1'h0;
      pixel_bus <= ~v;
      repeat (4) @(posedge pixel_clock);
   endtask : line
endmodule : dhp_host_model

`default_nettype wire

/* tb/dhp_port_bench.sv */
// Self-checking bench of the display host port
`timescale 1ns/10ps
`default_nettype none

module dhp_port_bench;
   import dhp_pkg::*;

   logic                mclk, sys_rst, panel_reset_n, status_clear;
   logic                serial_clock, serial_cs_n, serial_write_in;
   logic                serial_read_out, serial_read_oe, word_valid, ctrl_ready;
   logic [7:0]          reply_byte, rd;
   logic                oe_seen;
   dhp_word_t           word_out;
   dhp_width_t          pixel_width;
   logic                pixel_clock, pixel_valid, line_sync_n, frame_sync_n;
   logic [23:0]         pixel_bus;
   dhp_pix_t            pix_out, last_pix;
   logic                pix_out_valid, line_error, frame_error;
   logic [15:0]         frame_count;
   int                  num_errors, tests_run, nwords, npix, n0, i;

   // Serial rows: flag, payload, reply byte
   localparam logic [16:0] SROWS [4] = '{{1'h0, 8'h3a, 8'hc5}, {1'h1, 8'h81, 8'h5a},
                                         {1'h1, 8'hff, 8'h00}, {1'h0, 8'h00, 8'hff}};
   // Pixel rows: width code, bus value, widened colour
   localparam logic [49:0] PROWS [3] = '{{2'h0, 24'h00a55a, 24'ha5aad6},
                                         {2'h1, 24'h03f00f, 24'hff003c},
                                         {2'h2, 24'h123456, 24'h123456}};

   dhp_port dut (.mclk(mclk), .sys_rst(sys_rst), .panel_reset_n(panel_reset_n),
      .serial_clock(serial_clock), .serial_cs_n(serial_cs_n),
      .serial_write_in(serial_write_in), .serial_read_out(serial_read_out),
      .serial_read_oe(serial_read_oe), .reply_byte(reply_byte), .word_out(word_out),
      .word_valid(word_valid), .ctrl_ready(ctrl_ready), .pixel_width(pixel_width),
      .pixel_clock(pixel_clock), .pixel_bus(pixel_bus), .pixel_valid(pixel_valid),
      .line_sync_n(line_sync_n), .frame_sync_n(frame_sync_n), .pix_out(pix_out),
      .pix_out_valid(pix_out_valid), .frame_count(frame_count), .line_error(line_error),
      .frame_error(frame_error), .status_clear(status_clear));

   dhp_host_model host (.serial_clock(serial_clock), .serial_cs_n(serial_cs_n),
      .serial_write_in(serial_write_in), .serial_read_out(serial_read_out),
      .pixel_clock(pixel_clock), .pixel_bus(pixel_bus), .pixel_valid(pixel_valid),
      .line_sync_n(line_sync_n), .frame_sync_n(frame_sync_n));

   //------------------------------------------------------------------
   // Clock, monitors and compare tasks
   //------------------------------------------------------------------
   initial begin
      mclk = 1'h0;
      forever #12.5 mclk = ~mclk;
   end

   always @(posedge mclk) if (word_valid === 1'h1) nwords <= nwords + 1;
   always @(posedge serial_clock) if (!serial_cs_n) oe_seen <= serial_read_oe;
   always @(posedge pixel_clock) begin
      if (pix_out_valid === 1'h1) begin
         npix     <= npix + 1;
         last_pix <= pix_out;
      end
   end

   task check_vec(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : check_vec

   task check_flag(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask : check_flag

   task wait_ready();
      for (int k = 0; k < 50 && ctrl_ready !== 1'h1; k++) @(negedge mclk);
      check_flag(ctrl_ready, 1'h1);
      repeat (6) @(posedge pixel_clock);
      @(negedge mclk);
   endtask : wait_ready

   task complete_run();
      $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run

   initial begin
      #2000000;
      num_errors++;
      complete_run();
   end

   //------------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------------
   initial begin
      {num_errors, tests_run} = '0;
      sys_rst = 1'h1;
      panel_reset_n = 1'h1;
      status_clear = 1'h0;
      reply_byte = 8'h00;
      pixel_width = DHP_BUS24;
      repeat (6) @(negedge mclk);
      check_flag(ctrl_ready, 1'h0);
      sys_rst = 1'h0;
      wait_ready();
      host.line(3, 24'h111111);
      check_vec(24'(npix), 24'h0);
      for (i = 0; i < 4; i++) begin
         @(negedge mclk) reply_byte = SROWS[i][7:0];
         n0 = nwords;
         host.xfer(SROWS[i][16:8], 9, 1'h1, rd);
         check_vec(24'(nwords - n0), 24'h1);
         check_vec({15'h0, word_out}, {15'h0, SROWS[i][16:8]});
         // A reply byte is latched at the end of a word and goes out in the next
         check_vec({16'h0, rd}, {16'h0, (i == 0) ? 8'h00 : SROWS[i-1][7:0]});
         check_flag(oe_seen, 1'h1);
         check_flag(serial_read_oe, 1'h0);
      end
      n0 = nwords;
      host.xfer(9'h1aa, 5, 1'h1, rd);
      host.xfer(9'h0c3, 9, 1'h1, rd);
      host.xfer(9'h155, 9, 1'h0, rd);
      check_vec(24'(nwords - n0), 24'h1);
      check_vec({15'h0, word_out}, {15'h0, 9'h0c3});
      for (i = 0; i < 3; i++) begin
         @(negedge mclk) pixel_width = dhp_width_t'(PROWS[i][49:48]);
         host.frame_start();
         host.line(2, PROWS[i][47:24]);
         check_vec(last_pix.rgb, PROWS[i][23:0]);
         check_vec({15'h0, last_pix.col}, 24'h1);
         check_vec({8'h0, frame_count}, 24'(i + 1));
      end
      check_flag(frame_error, 1'h1);
      check_flag(line_error, 1'h1);
      @(negedge mclk) status_clear = 1'h1;
      @(negedge mclk) status_clear = 1'h0;
      repeat (2) @(negedge mclk);
      check_flag(line_error, 1'h0);
      check_flag(frame_error, 1'h0);
      n0 = npix;
      host.line(480, 24'h0f0f0f);
      check_vec(24'(npix - n0), 24'd480);
      check_vec({15'h0, last_pix.col}, 24'h1df);
      check_vec({14'h0, last_pix.row}, 24'h1);
      check_flag(line_error, 1'h0);
      host.line(5, 24'h0f0f0f);
      check_flag(line_error, 1'h1);
      @(negedge mclk) panel_reset_n = 1'h0;
      repeat (8) @(negedge mclk);
      check_flag(ctrl_ready, 1'h0);
      check_flag(line_error, 1'h0);
      check_vec({8'h0, frame_count}, 24'h0);
      panel_reset_n = 1'h1;
      wait_ready();
      host.xfer(9'h1e7, 9, 1'h1, rd);
      check_vec({15'h0, word_out}, {15'h0, 9'h1e7});
      complete_run();
   end
endmodule : dhp_port_bench

`default_nettype wire
